// file: stpidx_defs.vh
/*
  Constants of the stepper indexer control block: register offsets, field
  positions, reset values, state codes and timing counts.
  Assumes a single 25 MHz clock; every count is in clock cycles.
*/
`ifndef STPIDX_DEFS_VH
`define STPIDX_DEFS_VH

// =====================================================================
// Clock and timing
// =====================================================================
`define STP_PWM_CYC 10'h1f4
`define STP_BLANK_CYC 10'h05e
`define STP_OC_CYC 10'h058
`define STP_FAST_CYC 10'h07d

// =====================================================================
// Indexer and current scaling
// =====================================================================
`define STP_HOME_IDX 7'h10
`define STP_SENSE_GAIN 8'h05
`define STP_PCT_FULL 15'h0064

// =====================================================================
// Register map (byte addresses) and reset values
// =====================================================================
`define STP_CTRL_ADDR 8'h00
`define STP_VREF_ADDR 8'h04
`define STP_STAT_ADDR 8'h08
`define STP_CURR_ADDR 8'h0c
`define STP_CTRL_RST 2'h2
`define STP_VREF_RST 8'hff

// Status register field positions.
`define STP_ST_IDX 0
`define STP_ST_DRV 7
`define STP_ST_OC 8
`define STP_ST_HOT 9
`define STP_ST_UVL 10
`define STP_ST_SLP 11
`define STP_ST_FS 16

// =====================================================================
// Decay selections and winding drive states
// =====================================================================
`define STP_DECAY_SLOW 2'h0
`define STP_DECAY_FAST 2'h1
`define STP_DECAY_MIXED 2'h2
`define STP_W_OFF 2'h0
`define STP_W_DRIVE 2'h1
`define STP_W_SLOW 2'h2
`define STP_W_FAST 2'h3

`endif

// file: stpidx_ctrl.v
/*
  Control logic of a two-winding bipolar stepper driver: step/direction
  indexer with 128-state sine table, bridge gating by clear, enable and
  sleep pins, fixed-frequency chopping with blanking and selectable decay,
  overcurrent, thermal and undervoltage fault handling, and an AXI4-Lite
  register slave.
  Assumes all pin inputs are asynchronous to aclk; the analog comparators
  (chop trip, FET current limit, die temperature, supply) are outside and
  arrive as logic levels.
*/
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`include "stpidx_defs.vh"

module stpidx_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  input wire step_in,
  input wire direction_select,
  input wire [2:0] resolution_select,
  input wire chip_clear_low,
  input wire output_enable_low,
  input wire sleep_request_low,
  input wire [7:0] fet_limit_active,
  input wire die_overtemp,
  input wire supply_undervolt,
  input wire [1:0] chop_trip,
  output wire [1:0] winding_a_state,
  output wire [1:0] winding_b_state,
  output wire winding_a_neg,
  output wire winding_b_neg,
  output wire [7:0] itrip_code_a,
  output wire [7:0] itrip_code_b,
  output wire fault_flag_low,
  output wire charge_pump_en,
  output wire aux_regulator_en
);

  localparam [9:0] PWM_C = `STP_PWM_CYC;
  localparam [9:0] BLANK_C = `STP_BLANK_CYC;
  localparam [9:0] FAST_C = `STP_FAST_CYC;
  localparam [9:0] OC_C = `STP_OC_CYC;
  localparam [7:0] CTRL_A = `STP_CTRL_ADDR;
  localparam [7:0] VREF_A = `STP_VREF_ADDR;

  // ===================================================================
  // Functions
  // ===================================================================
  // Quarter-wave sine magnitude in percent, 33 points over 0..90 deg.
  function [6:0] qsin;
    input [5:0] k;
    begin
      case (k)
        6'h00: qsin = 7'd0;   6'h01: qsin = 7'd5;   6'h02: qsin = 7'd10;
        6'h03: qsin = 7'd15;  6'h04: qsin = 7'd20;  6'h05: qsin = 7'd24;
        6'h06: qsin = 7'd29;  6'h07: qsin = 7'd34;  6'h08: qsin = 7'd38;
        6'h09: qsin = 7'd43;  6'h0a: qsin = 7'd47;  6'h0b: qsin = 7'd51;
        6'h0c: qsin = 7'd56;  6'h0d: qsin = 7'd60;  6'h0e: qsin = 7'd63;
        6'h0f: qsin = 7'd67;  6'h10: qsin = 7'd71;  6'h11: qsin = 7'd74;
        6'h12: qsin = 7'd77;  6'h13: qsin = 7'd80;  6'h14: qsin = 7'd83;
        6'h15: qsin = 7'd86;  6'h16: qsin = 7'd88;  6'h17: qsin = 7'd90;
        6'h18: qsin = 7'd92;  6'h19: qsin = 7'd94;  6'h1a: qsin = 7'd96;
        6'h1b: qsin = 7'd97;  6'h1c: qsin = 7'd98;  6'h1d: qsin = 7'd99;
        default: qsin = 7'd100;
      endcase
    end
  endfunction

  // Signed sine of table state k (0..127): {negative, magnitude percent}.
  function [7:0] sin_pct;
    input [6:0] k;
    reg [5:0] r;
    begin
      r = {1'b0, k[4:0]};
      if (k[5]) begin
        r = 6'd32 - r;
      end
      sin_pct = {k[6], qsin(r)};
    end
  endfunction

  // Register decode shared by the read and write paths: {hit, index}.
  function [2:0] reg_dec;
    input [7:0] a;
    begin
      reg_dec = {(a[7:4] == 4'h0) && (a[1:0] == 2'h0), a[3:2]};
    end
  endfunction

  // ===================================================================
  // Pin synchronisers
  // ===================================================================
  // Every pin passes two flops; only the second stage is read.
  reg [19:0] pin_s1_q;
  reg [19:0] pin_s2_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 20'h00000;
      pin_s2_q <= 20'h00000;
    end else begin
      pin_s1_q <= {step_in, direction_select, resolution_select, chip_clear_low,
                   output_enable_low, sleep_request_low, fet_limit_active,
                   die_overtemp, supply_undervolt, chop_trip};
      pin_s2_q <= pin_s1_q;
    end
  end

  wire s_step = pin_s2_q[19];
  wire s_dir = pin_s2_q[18];
  wire [2:0] s_mode = pin_s2_q[17:15];
  wire s_clr_n = pin_s2_q[14];
  wire s_oe_n = pin_s2_q[13];
  wire s_slp_n = pin_s2_q[12];
  wire [7:0] s_fet = pin_s2_q[11:4];
  wire s_ot = pin_s2_q[3];
  wire s_uv = pin_s2_q[2];
  wire [1:0] s_trip = pin_s2_q[1:0];

  // ===================================================================
  // Operating gates
  // ===================================================================
  reg oc_q;
  reg [1:0] decay_q;
  reg [7:0] vref_q;
  // Clear and undervoltage both send the indexer home and clear the overcurrent latch; the registers keep their values.
  wire logic_clr = !s_clr_n || s_uv;
  wire step_ok = s_slp_n && !logic_clr && !s_oe_n;
  wire drive_ok = step_ok && !oc_q && !s_ot;

  // ===================================================================
  // Step edge detection and indexer
  // ===================================================================
  reg step_prev_q;
  reg [6:0] idx_q;
  reg [6:0] stride;
  // Mode picks the stride through the 128-state table; codes above
  // 1/32 also run at 1/32.
  always @* begin
    case (s_mode)
      3'h0: stride = 7'h20;
      3'h1: stride = 7'h10;
      3'h2: stride = 7'h08;
      3'h3: stride = 7'h04;
      3'h4: stride = 7'h02;
      default: stride = 7'h01;
    endcase
  end

  // Direction is sampled on the same synchronised edge as step. The
  // edge history keeps tracking while clear, undervoltage or disable refuse
  // steps (it freezes in sleep), so a high step level at enable time does
  // not count as a new edge.
  always @(posedge aclk) begin
    if (!aresetn) begin
      step_prev_q <= 1'b0;
      idx_q <= `STP_HOME_IDX;
    end else if (s_slp_n) begin
      step_prev_q <= s_step;
      if (logic_clr) begin
        idx_q <= `STP_HOME_IDX;
      end else if (step_ok && s_step && !step_prev_q) begin
        if (s_dir) begin
          idx_q <= idx_q + stride;
        end else begin
          idx_q <= idx_q - stride;
        end
      end
    end
  end

  // ===================================================================
  // Current references
  // ===================================================================
  // Winding A follows cosine, B follows sine. The trip code scales the
  // table percentage by the reference; the sense amplifier gain applies
  // in the analog comparator, so full scale is reference over gain.
  wire [7:0] pct_a = sin_pct(idx_q + 7'h20);
  wire [7:0] pct_b = sin_pct(idx_q);
  wire [14:0] prod_a = {8'h00, pct_a[6:0]} * {7'h00, vref_q};
  wire [14:0] prod_b = {8'h00, pct_b[6:0]} * {7'h00, vref_q};
  wire [14:0] quot_a = prod_a / `STP_PCT_FULL;
  wire [14:0] quot_b = prod_b / `STP_PCT_FULL;
  wire [7:0] fs_code = vref_q / `STP_SENSE_GAIN;
  reg [7:0] itrip_a_q;
  reg [7:0] itrip_b_q;
  reg neg_a_q;
  reg neg_b_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      itrip_a_q <= 8'h00;
      itrip_b_q <= 8'h00;
      neg_a_q <= 1'b0;
      neg_b_q <= 1'b0;
    end else begin
      itrip_a_q <= quot_a[7:0];
      itrip_b_q <= quot_b[7:0];
      neg_a_q <= pct_a[7];
      neg_b_q <= pct_b[7];
    end
  end

  // ===================================================================
  // PWM period divider
  // ===================================================================
  // Frozen in sleep, standing in for the halted internal clocks.
  reg [9:0] pwm_cnt_q;
  reg pwm_tick_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt_q <= 10'h000;
      pwm_tick_q <= 1'b0;
    end else if (!s_slp_n) begin
      pwm_tick_q <= 1'b0;
    end else if (pwm_cnt_q == PWM_C - 10'h001) begin
      pwm_cnt_q <= 10'h000;
      pwm_tick_q <= 1'b1;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 10'h001;
      pwm_tick_q <= 1'b0;
    end
  end

  // ===================================================================
  // Chopping state machine, one per winding
  // ===================================================================
  wire [1:0] wst [0:1];
  genvar w;
  generate
    for (w = 0; w < 2; w = w + 1) begin : g_wind
      reg [1:0] st_q;
      reg [9:0] cnt_q;
      assign wst[w] = st_q;
      // Drive until a trip past blanking, then decay to the period end.
      // Mixed decay runs fast for a fixed share, then slow.
      always @(posedge aclk) begin
        if (!aresetn) begin
          st_q <= `STP_W_OFF;
          cnt_q <= 10'h000;
        end else if (!drive_ok) begin
          st_q <= `STP_W_OFF;
          cnt_q <= 10'h000;
        end else begin
          if (cnt_q != 10'h3ff) begin
            cnt_q <= cnt_q + 10'h001;
          end
          case (st_q)
            `STP_W_OFF: begin
              st_q <= `STP_W_DRIVE;
              cnt_q <= 10'h000;
            end
            `STP_W_DRIVE: begin
              if (s_trip[w] && cnt_q >= BLANK_C) begin
                cnt_q <= 10'h000;
                if (decay_q == `STP_DECAY_SLOW) begin
                  st_q <= `STP_W_SLOW;
                end else begin
                  st_q <= `STP_W_FAST;
                end
              end
            end
            `STP_W_SLOW: begin
              if (pwm_tick_q) begin
                st_q <= `STP_W_DRIVE;
                cnt_q <= 10'h000;
              end
            end
            default: begin
              if (pwm_tick_q) begin
                st_q <= `STP_W_DRIVE;
                cnt_q <= 10'h000;
              end else if (decay_q == `STP_DECAY_MIXED &&
                           cnt_q >= FAST_C - 10'h001) begin
                st_q <= `STP_W_SLOW;
              end
            end
          endcase
        end
      end
    end
  endgenerate

  // ===================================================================
  // Overcurrent qualification and fault flag
  // ===================================================================
  // Any FET current limit counts, whichever side or short it is, and the
  // path never looks at the chop comparators.
  reg [9:0] oc_cnt_q;
  reg fault_n_q;
  reg pump_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      oc_cnt_q <= 10'h000;
      oc_q <= 1'b0;
      fault_n_q <= 1'b1;
      pump_q <= 1'b0;
    end else begin
      pump_q <= s_slp_n;
      if (!s_slp_n || logic_clr) begin
        oc_cnt_q <= 10'h000;
        oc_q <= 1'b0;
      end else if (|s_fet) begin
        if (oc_cnt_q >= OC_C - 10'h001) begin
          oc_q <= 1'b1;
        end else begin
          oc_cnt_q <= oc_cnt_q + 10'h001;
        end
      end else begin
        oc_cnt_q <= 10'h000;
      end
      // Released in the cycle after the latch clears or the heat falls.
      fault_n_q <= !(oc_q || (s_ot && s_slp_n));
    end
  end

  // ===================================================================
  // AXI4-Lite slave
  // ===================================================================
  reg awready_q;
  reg wready_q;
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg wstrb0_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  wire [2:0] wdec = reg_dec(awaddr_q);
  wire [2:0] rdec = reg_dec(araddr);

  // Address and data are taken in either order; the write lands once
  // both are held, and the response is raised in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      decay_q <= `STP_CTRL_RST;
      vref_q <= `STP_VREF_RST;
    end else begin
      if (awvalid && awready_q) begin
        awaddr_q <= awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        wdata_q <= wdata;
        wstrb0_q <= wstrb[0];
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (aw_have_q && w_have_q && !bvalid_q) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wdec[2] ? 2'h0 : 2'h2;
        if (wdec[2] && wstrb0_q && wdec[1:0] == CTRL_A[3:2]) begin
          decay_q <= (wdata_q[1:0] == 2'h3) ? `STP_DECAY_MIXED : wdata_q[1:0];
        end
        if (wdec[2] && wstrb0_q && wdec[1:0] == VREF_A[3:2]) begin
          vref_q <= wdata_q[7:0];
        end
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Reads answer one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rdec[2] ? 2'h0 : 2'h2;
      rdata_q <= 32'h00000000;
      if (rdec[2]) begin
        case (rdec[1:0])
          2'h0: rdata_q <= {30'h00000000, decay_q};
          2'h1: rdata_q <= {24'h000000, vref_q};
          2'h2: begin
            rdata_q[`STP_ST_IDX +: 7] <= idx_q;
            rdata_q[`STP_ST_DRV] <= drive_ok;
            rdata_q[`STP_ST_OC] <= oc_q;
            rdata_q[`STP_ST_HOT] <= s_ot;
            rdata_q[`STP_ST_UVL] <= s_uv;
            rdata_q[`STP_ST_SLP] <= !s_slp_n;
            rdata_q[`STP_ST_FS +: 8] <= fs_code;
          end
          default: rdata_q <= {6'h00, neg_b_q, neg_a_q, itrip_b_q,
                               8'h00, itrip_a_q};
        endcase
      end
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ===================================================================
  // Outputs
  // ===================================================================
  assign awready = awready_q;
  assign wready = wready_q;
  assign bresp = bresp_q;
  assign bvalid = bvalid_q;
  assign arready = arready_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign rvalid = rvalid_q;
  assign winding_a_state = wst[0];
  assign winding_b_state = wst[1];
  assign winding_a_neg = neg_a_q;
  assign winding_b_neg = neg_b_q;
  assign itrip_code_a = itrip_a_q;
  assign itrip_code_b = itrip_b_q;
  assign fault_flag_low = fault_n_q;
  assign charge_pump_en = pump_q;
  assign aux_regulator_en = pump_q;

endmodule // stpidx_ctrl

// file: sic_ctrl_checker.sv
/*
  Concurrent pin-side checks of stpidx_ctrl.
  Assumes the single aclk domain and the counts of stpidx_defs.vh.
*/
`include "stpidx_defs.vh"
// ====================
// Pin-side checker
// ====================
module sic_ctrl_checker (
  input wire aclk,
  input wire aresetn,
  input wire chip_clear_low,
  input wire output_enable_low,
  input wire sleep_request_low,
  input wire [7:0] fet_limit_active,
  input wire die_overtemp,
  input wire supply_undervolt,
  input wire [1:0] winding_a_state,
  input wire [1:0] winding_b_state,
  input wire fault_flag_low,
  input wire charge_pump_en,
  input wire aux_regulator_en
);
  timeunit 1ns;
  timeprecision 1ps;
  int oc_cnt_q;
  logic oc_seen_q;
  int drv_cnt_q;
  int dec_cnt_q;
  logic off;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both bridges released.
  assign off = (winding_a_state == 2'h0) && (winding_b_state == 2'h0);
  // Raw overcurrent count; any recovery pin wipes it.
  always @(posedge aclk) begin
    if (!aresetn || !chip_clear_low || !sleep_request_low || supply_undervolt) begin
      oc_cnt_q <= 0;
      oc_seen_q <= 1'h0;
    end else begin
      oc_cnt_q <= (fet_limit_active != 8'h00) ? oc_cnt_q + 1 : 0;
      if (oc_cnt_q > `STP_OC_CYC + 6) begin
        oc_seen_q <= 1'h1;
      end
    end
  end
  // Run lengths of winding A phases.
  always @(posedge aclk) begin
    drv_cnt_q <= (winding_a_state == 2'h1) ? drv_cnt_q + 1 : 0;
    dec_cnt_q <= winding_a_state[1] ? dec_cnt_q + 1 : 0;
  end
  // Six samples cover the two sync flops and the output flop.
  chk_clear_off: assert property (
    (!chip_clear_low) [*6] |-> off) else $error("Bridges driven during clear.");
  chk_enable_off: assert property (
    output_enable_low [*6] |-> off) else $error("Bridges driven while disabled.");
  chk_sleep_off: assert property (
    (!sleep_request_low) [*6] |-> off && !charge_pump_en && !aux_regulator_en)
    else $error("Power stages alive in sleep.");
  chk_uv_off: assert property (
    supply_undervolt [*6] |-> off) else $error("Bridges driven in undervoltage.");
  chk_oc_trip: assert property (
    (oc_cnt_q == `STP_OC_CYC + 6) |-> !fault_flag_low && off)
    else $error("Limit did not shut down.");
  chk_oc_latch: assert property (
    oc_seen_q && chip_clear_low && sleep_request_low && !supply_undervolt |-> !fault_flag_low)
    else $error("Latch released early.");
  chk_thermal_flag: assert property (
    (die_overtemp && sleep_request_low) [*6] |-> !fault_flag_low && off)
    else $error("Overtemperature not reported.");
  chk_fault_release: assert property (
    (!chip_clear_low && !die_overtemp) [*6] |-> fault_flag_low)
    else $error("Fault held after recovery.");
  chk_blank_hold: assert property (
    ($past(winding_a_state) == 2'h1) && winding_a_state[1] |-> drv_cnt_q >= `STP_BLANK_CYC - 1)
    else $error("Drive shorter than blanking.");
  chk_decay_bound: assert property (
    winding_a_state[1] |-> dec_cnt_q < `STP_PWM_CYC) else $error("Decay outlasted the period.");
endmodule // sic_ctrl_checker

bind stpidx_ctrl sic_ctrl_checker chk_u (.aclk, .aresetn, .chip_clear_low, .output_enable_low,
  .sleep_request_low, .fet_limit_active, .die_overtemp, .supply_undervolt, .winding_a_state,
  .winding_b_state, .fault_flag_low, .charge_pump_en, .aux_regulator_en);

// file: sic_motion_model.sv
/*
  Motion controller model driving step, direction and mode pins.
  Assumes it shares aclk and sees the sleep pin.
*/
// ====================
// Motion controller
// ====================
module sic_motion_model #(
  parameter int WAKE_CYC = 25000
) (
  input wire logic aclk,
  input wire logic sleep_request_low,
  output logic step_in,
  output logic direction_select,
  output logic [2:0] resolution_select
);
  timeunit 1ns;
  timeprecision 1ps;
  int awake_q = WAKE_CYC;
  // Idle: step low, forward, full step.
  initial begin
    step_in = 1'h0;
    direction_select = 1'h1;
    resolution_select = 3'h0;
  end
  // Cycles since wake, saturating.
  always @(posedge aclk) begin
    if (!sleep_request_low) begin
      awake_q <= 0;
    end else if (awake_q < WAKE_CYC) begin
      awake_q <= awake_q + 1;
    end
  end
  // One step; early skips the settle wait.
  task automatic pulse(input logic dir, input logic [2:0] mode, input bit early);
    while (!early && awake_q < WAKE_CYC) begin
      @(posedge aclk);
    end
    @(posedge aclk);
    direction_select <= dir;
    resolution_select <= mode;
    repeat (4) @(posedge aclk);
    step_in <= 1'h1;
    repeat (4) @(posedge aclk);
    step_in <= 1'h0;
    repeat (4) @(posedge aclk);
  endtask
endmodule // sic_motion_model

// file: tb_stepper_indexer_control.sv
/*
  Self-checking bench of stpidx_ctrl with a motion controller model.
  Assumes a 25 MHz aclk and an AXI4-Lite slave.
*/
`include "stpidx_defs.vh"
`define CHK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("BAD %s expected %0h got %0h", what, exp, got); \
    end \
  end
// ====================
// Bench top
// ====================
module tb_stepper_indexer_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic chip_clear_low = 1'h1, output_enable_low = 1'h1, sleep_request_low = 1'h1;
  logic die_overtemp = 1'h0, supply_undervolt = 1'h0;
  logic [7:0] fet_limit_active = 8'h00;
  logic [1:0] chop_trip = 2'h0;
  wire awready, wready, bvalid, arready, rvalid, step_in, direction_select;
  wire fault_flag_low, charge_pump_en, aux_regulator_en;
  wire [1:0] bresp, rresp, winding_a_state, winding_b_state;
  wire [31:0] rdata;
  wire [2:0] resolution_select;
  int checks = 0;
  int miscompares = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [6:0] exp_idx = 7'h10;

  stpidx_ctrl dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .step_in, .direction_select, .resolution_select, .chip_clear_low,
    .output_enable_low, .sleep_request_low, .fet_limit_active, .die_overtemp, .supply_undervolt,
    .chop_trip, .winding_a_state, .winding_b_state, .winding_a_neg(), .winding_b_neg(),
    .itrip_code_a(), .itrip_code_b(), .fault_flag_low, .charge_pump_en, .aux_regulator_en);
  sic_motion_model mc_u (.aclk, .sleep_request_low, .step_in, .direction_select,
    .resolution_select);

  // Free-running 40 ns clock.
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // AW and W go together; each drops at its own ready.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      t++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!(bvalid && bready) && t < 200);
    r = bresp;
    bready <= 1'h0;
    if (t >= 200) miscompares++;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      t++;
      if (arready) arvalid <= 1'h0;
    end while (!(rvalid && rready) && t < 200);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (t >= 200) miscompares++;
  endtask

  // Bounded wait while (winding A == s) differs from eq.
  task automatic wait_a(input logic [1:0] s, input bit eq, output int n);
    n = 0;
    while (((winding_a_state === s) != eq) && n < 1000) begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic step_chk(input logic dir, input logic [2:0] m);
    logic [6:0] s;
    s = (m >= 3'h5) ? 7'h01 : (7'h20 >> m);
    mc_u.pulse(dir, m, 1'h0);
    exp_idx = dir ? exp_idx + s : exp_idx - s;
    axi_rd(8'h08, rd, rsp);
    `CHK("index", exp_idx, rd[6:0])
  endtask

  task automatic t_regs;
    axi_rd(8'h08, rd, rsp);
    `CHK("status", 32'h00330010, rd & 32'h00ff0f7f)
    axi_wr(8'h04, 32'h00000064, rsp);
    axi_rd(8'h0c, rd, rsp);
    `CHK("itrip home", 32'h00470047, rd)
    axi_wr(8'h10, 32'h00000001, rsp);
    `CHK("bresp", 2'h2, rsp)
    axi_rd(8'h14, rd, rsp);
    `CHK("rresp", 2'h2, rsp)
    $display("regs test done");
  endtask

  task automatic t_step;
    output_enable_low <= 1'h0;
    repeat (6) @(posedge aclk);
    `CHK("drive", 2'h1, winding_a_state)
    for (int m = 0; m < 8; m++) step_chk(1'h1, 3'(m));
    step_chk(1'h0, 3'h7);
    step_chk(1'h0, 3'h0);
    axi_rd(8'h0c, rd, rsp);
    `CHK("itrip 135", 32'h01470047, rd)
    $display("step test done");
  endtask

  task automatic t_ignore;
    output_enable_low <= 1'h1;
    repeat (6) @(posedge aclk);
    `CHK("off", 2'h0, winding_b_state)
    mc_u.pulse(1'h1, 3'h7, 1'h0);
    axi_rd(8'h08, rd, rsp);
    `CHK("held", exp_idx, rd[6:0])
    output_enable_low <= 1'h0;
    chip_clear_low <= 1'h0;
    mc_u.pulse(1'h1, 3'h0, 1'h0);
    chip_clear_low <= 1'h1;
    exp_idx = 7'h10;
    repeat (6) @(posedge aclk);
    axi_rd(8'h08, rd, rsp);
    `CHK("home", exp_idx, rd[6:0])
    $display("ignore test done");
  endtask

  task automatic decay_case(input logic [1:0] m, input logic [1:0] first, input logic [1:0] later);
    int n;
    axi_wr(8'h00, {30'h0, m}, rsp);
    chop_trip <= 2'h3;
    wait_a(2'h1, 1'h0, n);
    wait_a(2'h1, 1'h1, n);
    wait_a(2'h1, 1'h0, n);
    `CHK("blank", 1'h1, n >= `STP_BLANK_CYC - 2)
    `CHK("decay", first, winding_a_state)
    repeat (140) @(posedge aclk);
    `CHK("late decay", later, winding_a_state)
    chop_trip <= 2'h0;
    wait_a(2'h1, 1'h1, n);
    `CHK("redrive", 1'h1, n < `STP_PWM_CYC)
    $display("decay test done");
  endtask

  task automatic t_faults;
    die_overtemp <= 1'h1;
    repeat (8) @(posedge aclk);
    `CHK("hot flag", 1'h0, fault_flag_low)
    die_overtemp <= 1'h0;
    repeat (8) @(posedge aclk);
    `CHK("hot resume", 1'h1, fault_flag_low)
    step_chk(1'h1, 3'h0);
    supply_undervolt <= 1'h1;
    repeat (8) @(posedge aclk);
    `CHK("uv off", 2'h0, winding_a_state)
    supply_undervolt <= 1'h0;
    exp_idx = 7'h10;
    repeat (8) @(posedge aclk);
    axi_rd(8'h08, rd, rsp);
    `CHK("uv home", exp_idx, rd[6:0])
    sleep_request_low <= 1'h0;
    repeat (8) @(posedge aclk);
    `CHK("sleep pump", 2'h0, {charge_pump_en, aux_regulator_en})
    mc_u.pulse(1'h1, 3'h0, 1'h1);
    sleep_request_low <= 1'h1;
    step_chk(1'h1, 3'h0);
    $display("fault test done");
  endtask

  task automatic t_oc;
    for (int k = 0; k < 8; k++) begin
      fet_limit_active <= 8'h01 << k;
      repeat (100) @(posedge aclk);
      fet_limit_active <= 8'h00;
      repeat (40) @(posedge aclk);
      `CHK("oc flag", 1'h0, fault_flag_low)
      axi_rd(8'h08, rd, rsp);
      `CHK("oc status", 1'h1, rd[8])
      if (k % 2 == 1) chip_clear_low <= 1'h0;
      else sleep_request_low <= 1'h0;
      repeat (8) @(posedge aclk);
      chip_clear_low <= 1'h1;
      sleep_request_low <= 1'h1;
      repeat (8) @(posedge aclk);
      `CHK("oc release", 1'h1, fault_flag_low)
    end
    fet_limit_active <= 8'h80;
    repeat (40) @(posedge aclk);
    fet_limit_active <= 8'h00;
    repeat (8) @(posedge aclk);
    `CHK("short limit", 1'h1, fault_flag_low)
    $display("overcurrent test done");
  endtask

  // Main sequence.
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    t_regs;
    t_step;
    t_ignore;
    decay_case(2'h0, 2'h2, 2'h2);
    decay_case(2'h1, 2'h3, 2'h3);
    decay_case(2'h2, 2'h3, 2'h2);
    t_faults;
    t_oc;
    conclude;
  end

  // Watchdog; the run needs about 30000 cycles.
  initial begin
    repeat (90000) @(posedge aclk);
    miscompares++;
    conclude;
  end
endmodule // tb_stepper_indexer_control
